// File: pwm_output_mode_steering.sv
// Output stage of the PWM controller: modes, steering, dead band, polarity and enables.
// Assumes period, rising and falling events arrive as one-cycle strobes on mclk_in.
`include "pwm_steer_cfg.svh"
module pwm_output_mode_steering
  import pwm_steer_pkg::*;
#(
  parameter int NUM_OUTS = `NUM_OUTS,
  parameter int DB_W     = `DB_W
) (
  // Clock and reset
  input  wire logic                mclk_in,
  input  wire logic                rst_n_in,
  // Module control
  input  wire logic                module_enable_in,
  input  wire logic [`MODE_W-1:0]  mode_in,
  input  wire logic                db_rise_en_in,
  input  wire logic                db_fall_en_in,
  input  wire logic [DB_W-1:0]     db_rise_time_in,
  input  wire logic [DB_W-1:0]     db_fall_time_in,
  // Output configuration
  input  wire logic [NUM_OUTS-1:0] output_steer_bit_in,
  input  wire logic [NUM_OUTS-1:0] output_polarity_reg_in,
  input  wire logic [NUM_OUTS-1:0] output_enable_reg_in,
  // Events
  input  wire logic                period_evt_in,
  input  wire logic                rise_evt_in,
  input  wire logic                fall_evt_in,
  // Pins
  output logic                     pwm_out_a,
  output logic                     pwm_out_b,
  output logic                     pwm_out_c,
  output logic                     pwm_out_d,
  output logic                     pwm_out_e,
  output logic                     pwm_out_f,
  output logic [NUM_OUTS-1:0]      pin_own_out,
  // Status
  output logic                     odd_period_out
);
  logic                enable_d;
  logic                odd;
  logic                pri;
  logic                cmp;
  logic                pri_on;
  logic                cmp_on;
  logic                db_rise_use;
  logic                db_fall_use;
  logic [NUM_OUTS-1:0] active;
  logic [NUM_OUTS-1:0] next_pins;
  logic [NUM_OUTS-1:0] pins;

  function automatic logic steer_mode(input logic [`MODE_W-1:0] m);
    return (m == `MODE_SINGLE) || (m == `MODE_COMP) || (m == `MODE_SIXSTEP);
  endfunction

  function automatic logic db_mode(input logic [`MODE_W-1:0] m);
    return (m == `MODE_COMP) || (m == `MODE_PP_COMP);
  endfunction

  // Only modes with dead band may use it
  assign db_rise_use = db_rise_en_in && db_mode(mode_in);
  assign db_fall_use = db_fall_en_in && db_mode(mode_in);

  pwm_dead_band #(.DB_W(DB_W)) u_db (
    .mclk_in      (mclk_in),
    .rst_n_in     (rst_n_in),
    .rise_in      (rise_evt_in),
    .fall_in      (fall_evt_in),
    .rise_en_in   (db_rise_use),
    .fall_en_in   (db_fall_use),
    .rise_time_in (db_rise_time_in),
    .fall_time_in (db_fall_time_in),
    .enable_in    (module_enable_in),
    .pri_on_out   (pri_on),
    .cmp_on_out   (cmp_on)
  );

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in)
      enable_d <= 1'b0;
    else
      enable_d <= module_enable_in;
  end

  // Parity starts even at enable; the first period event begins an odd period
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in)
      odd <= 1'b0;
    else if (module_enable_in && !enable_d)
      odd <= 1'b0;
    else if (module_enable_in && period_evt_in)
      odd <= ~odd;
  end
  assign odd_period_out = odd;

  // Primary: off at fall, on after rising band; complement the mirror
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pri <= 1'b0;
      cmp <= 1'b0;
    end else if (!module_enable_in) begin
      pri <= 1'b0;
      cmp <= 1'b0;
    end else begin
      if (fall_evt_in)
        pri <= 1'b0;
      else if (pri_on)
        pri <= 1'b1;
      if (rise_evt_in)
        cmp <= 1'b0;
      else if (cmp_on)
        cmp <= 1'b1;
    end
  end

  // Steering in steering modes; fixed routing elsewhere
  always_comb begin
    active = '0;
    unique case (mode_in)
      `MODE_SINGLE, `MODE_SIXSTEP: begin
        active = {NUM_OUTS{pri}} & output_steer_bit_in;
      end
      `MODE_COMP: begin
        active = ({NUM_OUTS{pri}} & output_steer_bit_in & NUM_OUTS'(`PRI_ROUTE_MASK))
               | ({NUM_OUTS{cmp}} & output_steer_bit_in & NUM_OUTS'(`CMP_ROUTE_MASK));
      end
      `MODE_PUSHPULL: begin
        active[`OUT_A] = pri && odd;
        active[`OUT_B] = pri && !odd;
      end
      `MODE_PP_COMP: begin
        active[`OUT_A] = pri && odd;
        active[`OUT_E] = cmp && odd;
        active[`OUT_B] = pri && !odd;
        active[`OUT_F] = cmp && !odd;
      end
      default: active = '0;
    endcase
  end

  // Inactive is low before polarity; polarity inverts each output alone
  assign next_pins = active ^ output_polarity_reg_in;

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in)
      pins <= '0;
    else
      pins <= next_pins;
  end

  // Released pins read low here; the port mux ignores them
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in)
      pin_own_out <= '0;
    else
      pin_own_out <= output_enable_reg_in;
  end

  assign pwm_out_a = pins[`OUT_A] & pin_own_out[`OUT_A];
  assign pwm_out_b = pins[`OUT_B] & pin_own_out[`OUT_B];
  assign pwm_out_c = pins[`OUT_C] & pin_own_out[`OUT_C];
  assign pwm_out_d = pins[`OUT_D] & pin_own_out[`OUT_D];
  assign pwm_out_e = pins[`OUT_E] & pin_own_out[`OUT_E];
  assign pwm_out_f = pins[`OUT_F] & pin_own_out[`OUT_F];

  // Unsteered output must sit at its inactive level, polarity included
  a_unsteered_idle: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (mode_in == `MODE_SINGLE && !output_steer_bit_in[`OUT_C])
    |=> (pins[`OUT_C] == $past(output_polarity_reg_in[`OUT_C])))
    else $error("unsteered output not inactive");
  a_single_rise: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (module_enable_in && mode_in == `MODE_SINGLE && rise_evt_in && !fall_evt_in)
    |=> ##1 (pins == ($past(output_steer_bit_in, 2) ^ $past(output_polarity_reg_in))))
    else $error("single mode rising edge not applied");
  a_single_fall: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (module_enable_in && mode_in == `MODE_SINGLE && fall_evt_in && $stable(mode_in))
    |=> ##1 (pins == $past(output_polarity_reg_in)))
    else $error("single mode falling edge not applied");
  a_pp_only_ab: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (mode_in == `MODE_PUSHPULL) |-> (active[`OUT_C] == 1'b0 && active[`OUT_F:`OUT_D] == 3'h0))
    else $error("push-pull drove a fixed-off output");
  a_pp_alternate: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (mode_in == `MODE_PUSHPULL) |-> !(active[`OUT_A] && active[`OUT_B]))
    else $error("push-pull drove both phases");
  a_comp_no_overlap: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (mode_in == `MODE_PP_COMP) |-> !(active[`OUT_A] && active[`OUT_E]) && !(active[`OUT_B] && active[`OUT_F]))
    else $error("primary and complement overlap");
  a_parity_toggle: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (module_enable_in && enable_d && period_evt_in) |=> (odd != $past(odd)))
    else $error("parity did not toggle");
  a_release_pin: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    !output_enable_reg_in[`OUT_A] |=> (!pin_own_out[`OUT_A] && !pwm_out_a))
    else $error("disabled pin still owned");
endmodule // pwm_output_mode_steering

// File: pwm_steer_cfg.svh
// Constants for the PWM output steering stage: mode codes, output indices, dead-band width.
// Assumes inclusion by the package and the design modules only.
`ifndef PWM_STEER_CFG_SVH
`define PWM_STEER_CFG_SVH
`define MODE_W          4
`define MODE_SINGLE     4'h0
`define MODE_COMP       4'h1
`define MODE_PUSHPULL   4'h2
`define MODE_PP_COMP    4'h3
`define MODE_SIXSTEP    4'h4
`define OUT_A           0
`define OUT_B           1
`define OUT_C           2
`define OUT_D           3
`define OUT_E           4
`define OUT_F           5
`define NUM_OUTS        6
`define DB_W            8
`define DB_ZERO         8'h00
`define DB_ONE          8'h01
`define PRI_ROUTE_MASK  6'h15
`define CMP_ROUTE_MASK  6'h1a
`endif

// File: pwm_steer_pkg.sv
// Types shared by the PWM output steering stage.
// Assumes the cfg header supplies the numeric constants.
`include "pwm_steer_cfg.svh"
package pwm_steer_pkg;
  typedef enum logic [1:0] {DB_IDLE, DB_RISE, DB_FALL} db_state_t;
endpackage

// File: pwm_dead_band.sv
// Dead-band delay sequencer: holds off the turn-on edge after an event.
// Assumes events are one-cycle strobes in the mclk_in domain.
`include "pwm_steer_cfg.svh"
module pwm_dead_band
  import pwm_steer_pkg::*;
#(
  parameter int DB_W = `DB_W
) (
  // Clock and reset
  input  wire logic            mclk_in,
  input  wire logic            rst_n_in,
  // Events and settings
  input  wire logic            rise_in,
  input  wire logic            fall_in,
  input  wire logic            rise_en_in,
  input  wire logic            fall_en_in,
  input  wire logic [DB_W-1:0] rise_time_in,
  input  wire logic [DB_W-1:0] fall_time_in,
  // Enable and turn-on strobes
  input  wire logic            enable_in,
  output logic                 pri_on_out,
  output logic                 cmp_on_out
);
  db_state_t       state;
  logic [DB_W-1:0] count;

  // Zero time or disabled band turns on in the event's own cycle
  always_comb begin
    pri_on_out = 1'b0;
    cmp_on_out = 1'b0;
    if (enable_in) begin
      if (rise_in && !(rise_en_in && rise_time_in != DB_W'(0)))
        pri_on_out = 1'b1;
      if (fall_in && !(fall_en_in && fall_time_in != DB_W'(0)))
        cmp_on_out = 1'b1;
      if (state == DB_RISE && count == DB_W'(1) && !fall_in)
        pri_on_out = 1'b1;
      if (state == DB_FALL && count == DB_W'(1) && !rise_in)
        cmp_on_out = 1'b1;
    end
  end

  // A new event aborts a pending band; a same-kind event in its last cycle still lets the stale turn-on fire
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= DB_IDLE;
      count <= '0;
    end else if (!enable_in) begin
      state <= DB_IDLE;
      count <= '0;
    end else if (rise_in && rise_en_in && rise_time_in != DB_W'(0)) begin
      state <= DB_RISE;
      count <= rise_time_in;
    end else if (fall_in && fall_en_in && fall_time_in != DB_W'(0)) begin
      state <= DB_FALL;
      count <= fall_time_in;
    end else if (rise_in || fall_in) begin
      state <= DB_IDLE;
      count <= '0;
    end else if (state != DB_IDLE) begin
      count <= count - DB_W'(1);
      if (count == DB_W'(1))
        state <= DB_IDLE;
    end
  end

  // Turn-on after rising band lands exactly rise_time cycles later
  a_rise_band_delay: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (enable_in && rise_in && !fall_in && rise_en_in && rise_time_in == DB_W'(2))
    ##1 (enable_in && !rise_in && !fall_in) [*2] |-> pri_on_out)
    else $error("rising dead band turn-on late");
  a_no_early_on: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (enable_in && rise_in && rise_en_in && rise_time_in > DB_W'(1)) |-> !pri_on_out)
    else $error("primary turned on during dead band");
endmodule // pwm_dead_band

// File: pwm_bridge_model.sv
// Behavioural model of the external transistor bridge fed by the six PWM pins.
// Assumes pins pair into half-bridge legs A/B, C/D and E/F (high side first).
module pwm_bridge_model (
  // Gate drive from the controller
  input  wire logic [5:0] gate_in,
  input  wire logic [5:0] own_in,
  // Switch state seen by the bench
  output logic [5:0]      switch_on_out,
  output logic            shoot_thru_out
);
  timeunit 1ns;
  timeprecision 100ps;
  // A released pin falls to the gate driver's pull-down, so its switch stays off
  assign switch_on_out  = gate_in & own_in;
  // Both switches of one leg on at once would short the supply
  assign shoot_thru_out = (switch_on_out[0] & switch_on_out[1]) | (switch_on_out[2] & switch_on_out[3]) |
                          (switch_on_out[4] & switch_on_out[5]);
endmodule // pwm_bridge_model

// File: pwm_output_mode_steering_tb.sv
// Self-checking bench for the PWM output steering stage.
// Assumes pins follow an event two edges later, plus any dead band.
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin err_count++; \
  $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module pwm_output_mode_steering_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic       mclk_in, rst_n_in, en, db_re, db_fe, per, rise, fall;
  logic [3:0] mode;
  logic [7:0] db_rt, db_ft;
  logic [5:0] steer, pol, own, own_seen, sw;
  logic       a, b, c, d, e, f, odd, shoot;
  int         err_count, tests_run, cycles;
  wire  [5:0] pins = {f, e, d, c, b, a};

  pwm_output_mode_steering i_pwm_output_mode_steering (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in), .module_enable_in(en), .mode_in(mode),
    .db_rise_en_in(db_re), .db_fall_en_in(db_fe), .db_rise_time_in(db_rt), .db_fall_time_in(db_ft),
    .output_steer_bit_in(steer), .output_polarity_reg_in(pol), .output_enable_reg_in(own),
    .period_evt_in(per), .rise_evt_in(rise), .fall_evt_in(fall),
    .pwm_out_a(a), .pwm_out_b(b), .pwm_out_c(c), .pwm_out_d(d), .pwm_out_e(e), .pwm_out_f(f),
    .pin_own_out(own_seen), .odd_period_out(odd));
  pwm_bridge_model i_pwm_bridge_model (.gate_in(pins), .own_in(own_seen), .switch_on_out(sw),
    .shoot_thru_out(shoot));

  initial begin
    mclk_in = 1'b0;
    forever #5 mclk_in = ~mclk_in;
  end

  task automatic step(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask
  // One-cycle strobe: 0 period, 1 rise, 2 fall; returns on the sampling edge
  task automatic ev(input int k);
    @(posedge mclk_in);
    if (k == 0) per <= 1'b1; else if (k == 1) rise <= 1'b1; else fall <= 1'b1;
    @(posedge mclk_in);
    per <= 1'b0; rise <= 1'b0; fall <= 1'b0;
  endtask
  // Bounce the module enable so parity restarts even before the first period
  task automatic cfg(input logic [3:0] m, input logic [5:0] s, input logic [5:0] p, input logic [5:0] o);
    @(posedge mclk_in);
    en <= 1'b0;
    @(posedge mclk_in);
    mode <= m; steer <= s; pol <= p; own <= o; en <= 1'b1;
    step(2);
  endtask

  task automatic t_single;
    cfg(4'h0, 6'h03, 6'h04, 6'h1f);
    `CHK("single idle", 6'h04, pins)
    `CHK("pin ownership", 6'h1f, own_seen)
    ev(1); step(2);
    `CHK("single rise", 6'h07, pins)
    ev(2); step(2);
    `CHK("single fall", 6'h04, pins)
    $display("test single done");
  endtask

  task automatic t_comp;
    cfg(4'h1, 6'h03, 6'h00, 6'h3f);
    @(posedge mclk_in);
    db_re <= 1'b1; db_fe <= 1'b1; db_rt <= 8'h02; db_ft <= 8'h02;
    ev(1); step(2);
    `CHK("comp rise gap", 6'h00, pins)
    step(3);
    `CHK("comp primary on", 6'h01, pins)
    ev(2); step(2);
    `CHK("comp fall gap", 6'h00, pins)
    step(2);
    `CHK("comp complement on", 6'h02, pins)
    `CHK("comp no shoot", 1'b0, shoot)
    `CHK("comp switch state", 6'h02, sw)
    @(posedge mclk_in);
    db_re <= 1'b0; db_fe <= 1'b0;
    $display("test complementary done");
  endtask

  task automatic t_pushpull;
    cfg(4'h2, 6'h3f, 6'h00, 6'h3f);
    ev(0); ev(1); step(2);
    `CHK("pp odd flag", 1'b1, odd)
    `CHK("pp odd rise", 6'h01, pins)
    ev(2); step(2);
    `CHK("pp odd fall", 6'h00, pins)
    ev(0); ev(1); step(2);
    `CHK("pp even flag", 1'b0, odd)
    `CHK("pp even rise", 6'h02, pins)
    ev(2);
    $display("test push-pull done");
  endtask

  task automatic t_ppcomp;
    cfg(4'h3, 6'h00, 6'h00, 6'h3f);
    ev(0); ev(1); step(2);
    `CHK("ppc odd rise", 6'h01, pins & 6'h1d)
    ev(2); step(2);
    `CHK("ppc odd fall", 6'h10, pins & 6'h1d)
    ev(0); ev(1); step(2);
    `CHK("ppc even rise", 6'h02, pins & 6'h2e)
    ev(2); step(2);
    `CHK("ppc even fall", 6'h20, pins & 6'h2e)
    $display("test push-pull complementary done");
  endtask

  task automatic t_sixstep;
    cfg(4'h4, 6'h21, 6'h00, 6'h3f);
    ev(1); step(2);
    `CHK("six first step", 6'h21, pins)
    @(posedge mclk_in);
    steer <= 6'h06;
    step(2);
    `CHK("six next step", 6'h06, pins)
    ev(2); step(2);
    `CHK("six fall", 6'h00, pins)
    $display("test six-step done");
  endtask

  task automatic t_refused;
    cfg(4'h7, 6'h3f, 6'h00, 6'h3f);
    ev(1); step(2);
    `CHK("unknown mode", 6'h00, pins)
    cfg(4'h0, 6'h3f, 6'h00, 6'h3f);
    @(posedge mclk_in);
    en <= 1'b0;
    ev(0); ev(1); step(2);
    `CHK("disabled pins", 6'h00, pins)
    `CHK("disabled parity", 1'b0, odd)
    $display("test disabled done");
  endtask

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Whole run needs well under a thousand cycles
  always @(posedge mclk_in) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      err_count++;
      complete_run();
    end
  end

  initial begin
    rst_n_in = 1'b0; en = 1'b0; mode = 4'h0; db_re = 1'b0; db_fe = 1'b0; db_rt = 8'h00; db_ft = 8'h00;
    steer = 6'h00; pol = 6'h00; own = 6'h00; per = 1'b0; rise = 1'b0; fall = 1'b0;
    err_count = 0; tests_run = 0; cycles = 0;
    repeat (3) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    t_single();
    t_comp();
    t_pushpull();
    t_ppcomp();
    t_sixstep();
    t_refused();
    complete_run();
  end
endmodule // pwm_output_mode_steering_tb
